// >>> core/shaper_pkg.sv
// Shared constants for the WAN cell shaper bank.
// Assumes a single system clock domain and an APB register slave.
package shaper_pkg;
  localparam int NUM_SHAPERS = 4;
  localparam logic [11:0] SHAPER0_CONFIG_ADDR = 12'h0730;
  localparam logic [11:0] SHAPER1_CONFIG_ADDR = 12'h0734;
  localparam logic [11:0] SHAPER2_CONFIG_ADDR = 12'h0738;
  localparam logic [11:0] SHAPER3_CONFIG_ADDR = 12'h073c;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h0740;
  localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h0744;
  localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h0748;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_WMASK = 32'h1ff3_fff7;
  localparam int EN_BIT = 0;
  localparam int SLOW_BIT = 1;
  localparam int THR_SEL_BIT = 2;
  localparam int PORT_LSB = 4;
  localparam int CLASS_LSB = 6;
  localparam int MEAS_LSB = 8;
  localparam int THR_LSB = 12;
  localparam int RED_LSB = 16;
  localparam int RATE_LSB = 20;
  localparam int CONG_BIT = 31;
  localparam int MEAS_BASE_LOG2 = 6;
  localparam logic [8:0] RATE_FLOOR = 9'h001;
  localparam logic [15:0] QLEN_ONE = 16'h0001;
  localparam logic [3:0] STRETCH_MAX = 4'hf;
endpackage

// >>> core/shaper_cfg_if.sv
// Per-shaper configuration and status between bank and shaper units.
// Assumes the bank drives config and the unit reports congestion.
`timescale 1ns/10ps
interface shaper_cfg_if;
  logic [31:0] cfg;
  logic congested;
  logic [8:0] slot_interval;
  modport bank (output cfg, input congested, input slot_interval);
  modport unit (input cfg, output congested, output slot_interval);
endinterface

// >>> core/shaper_unit.sv
// One rate shaper: measurement window, congestion test, slot stretching.
// Assumes queue length and departure pulses on the system clock.
`timescale 1ns/10ps
module shaper_unit
  import shaper_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  shaper_cfg_if.unit cif,
  input wire logic [15:0] qlen,
  input wire logic depart,
  output logic slot_tick
);
  logic [21:0] win_cnt_r;
  logic [15:0] dep_cnt_r, last_dep_r;
  logic [3:0] stretch_r;
  logic [3:0] relax_cnt_r;
  logic [12:0] slot_cnt_r;
  logic cong_r;
  // Longest window is 64 * 2^15 cycles, so 22 bits are needed
  logic [21:0] win_len;
  logic [15:0] thr_val, cmp_val;
  logic [3:0] red_cnt;
  logic slow_en, win_end, cong_now;
  logic [12:0] eff_interval;

  // Decode fields, ignored unless slow-down enabled
  assign slow_en = cif.cfg[EN_BIT] & cif.cfg[SLOW_BIT];
  assign win_len = 22'(1) << (MEAS_BASE_LOG2 + int'(cif.cfg[MEAS_LSB +: 4]));
  // Shift count kept at 5 bits so T = 15 gives the full 16-bit mask
  assign thr_val = 16'((QLEN_ONE << (5'(cif.cfg[THR_LSB +: 4]) + 5'h01)) - QLEN_ONE);
  assign red_cnt = 4'((5'h02 << cif.cfg[RED_LSB +: 2]) - 5'h01);
  assign win_end = (win_cnt_r == win_len - 22'(1));
  // Threshold only read when both selects set
  assign cmp_val = cif.cfg[THR_SEL_BIT] ? thr_val : last_dep_r;
  assign cong_now = slow_en && (qlen > cmp_val);
  assign cif.congested = cong_r;
  assign cif.slot_interval = cif.cfg[RATE_LSB +: 9];

  // Window counter, plain clock cycles unaffected by stretching
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r <= '0;
      dep_cnt_r <= '0;
      last_dep_r <= '0;
    end else if (ce) begin
      win_cnt_r <= win_end ? '0 : win_cnt_r + 22'(1);
      if (win_end) begin
        last_dep_r <= dep_cnt_r;
        dep_cnt_r <= 16'(depart);
      end else if (depart) begin
        dep_cnt_r <= dep_cnt_r + 16'(1);
      end
    end
  end

  // Stretch grows per congested window, relaxes every red_cnt + 1 clear windows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_r <= '0;
      relax_cnt_r <= '0;
      cong_r <= 1'b0;
    end else if (ce) begin
      cong_r <= 1'b0;
      if (!slow_en) begin
        stretch_r <= '0;
        relax_cnt_r <= '0;
      end else if (win_end) begin
        if (cong_now) begin
          if (stretch_r != STRETCH_MAX) stretch_r <= stretch_r + 4'h1;
          relax_cnt_r <= '0;
          cong_r <= 1'b1;
        end else if (stretch_r != 4'h0) begin
          if (relax_cnt_r >= red_cnt) begin
            stretch_r <= stretch_r - 4'h1;
            relax_cnt_r <= '0;
          end else begin
            relax_cnt_r <= relax_cnt_r + 4'h1;
          end
        end
      end
    end
  end

  // Timeslot reference: rate plus rate * stretch / 16; disabled shaper never ticks
  assign eff_interval = 13'(cif.cfg[RATE_LSB +: 9]) + 13'(cif.cfg[RATE_LSB +: 9]) *
    13'(stretch_r) / 13'(16);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt_r <= '0;
      slot_tick <= 1'b0;
    end else if (ce) begin
      slot_tick <= 1'b0;
      if (!cif.cfg[EN_BIT]) begin
        slot_cnt_r <= '0;
      end else if (slot_cnt_r + 13'(1) >= eff_interval) begin
        slot_cnt_r <= '0;
        slot_tick <= 1'b1;
      end else begin
        slot_cnt_r <= slot_cnt_r + 13'(1);
      end
    end
  end

  AST_DISABLED_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
    !cif.cfg[EN_BIT] |=> !slot_tick) else $error("disabled shaper ticked");
  AST_NO_SLOW_NO_CONG: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_en |=> !cong_r) else $error("congestion with slow-down off");
endmodule

// >>> core/wan_cell_shaper_bank.sv
// Bank of four WAN class-queue rate shapers with an APB register slave.
// Assumes the queue engine supplies per-port/class lengths and departures.
//
// Contract
// - Shaped WAN pairs override circuit queue select
// - Slow-down stretches the shaper time reference
// - Compare select: departures or threshold
// - Slow-down off ignores window, select, factor
// - Threshold used only with both enables
// - Window is 64 times two^code cycles
// - Threshold equals two^(T+1) minus one
// - Reduction factor decodes 2, 4, 8, 16
// - Rate field is cycles per timeslot
// - Bit 31 congestion flag, cleared on read
// - Port bits 5:4, class bits 7:6
`timescale 1ns/10ps
module wan_cell_shaper_bank
  import shaper_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [255:0] class_qlen,
  input wire logic [15:0] class_depart,
  input wire logic [1:0] lookup_port,
  input wire logic [1:0] lookup_class,
  input wire logic [1:0] circuit_queue_select,
  output logic [1:0] queue_select_out,
  output logic queue_shaped,
  output logic [3:0] slot_tick_out,
  output logic irq
);
  logic [31:0] cfg_r [NUM_SHAPERS];
  logic [3:0] cong_flag_r;
  logic [3:0] irq_stat_r, irq_en_r;
  logic [3:0] slot_tick;
  logic [3:0] cong_evt;
  logic [3:0] hit;
  logic [3:0] read_clr;
  logic [1:0] hit_idx;
  logic [31:0] rdata_nxt;
  logic wr_acc, rd_acc, addr_ok;
  logic [3:0] cfg_sel;

  shaper_cfg_if cif [NUM_SHAPERS] ();

  // One unit per shaper, each fed its selected class queue
  for (genvar i = 0; i < NUM_SHAPERS; i++) begin : g_shp
    logic [3:0] qid;
    assign qid = {cfg_r[i][CLASS_LSB +: 2], cfg_r[i][PORT_LSB +: 2]};
    assign cif[i].cfg = cfg_r[i];
    assign cong_evt[i] = cif[i].congested;
    assign cfg_sel[i] = (paddr == SHAPER0_CONFIG_ADDR + 12'(4 * i));
    assign hit[i] = cfg_r[i][EN_BIT] && (cfg_r[i][PORT_LSB +: 2] == lookup_port) &&
      (cfg_r[i][CLASS_LSB +: 2] == lookup_class);
    shaper_unit u_unit (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .cif(cif[i]),
      .qlen(class_qlen[16 * qid +: 16]),
      .depart(class_depart[qid]),
      .slot_tick(slot_tick[i])
    );
  end

  // APB decode; zero-wait-state slave
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite && pready;
  assign addr_ok = (|cfg_sel) || paddr == IRQ_STATUS_ADDR || paddr == IRQ_CLEAR_ADDR ||
    paddr == IRQ_ENABLE_ADDR;
  assign read_clr = rd_acc ? cfg_sel : 4'h0;

  // Config writes; read-only bits masked, selectors relied upon static
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NUM_SHAPERS; k++) cfg_r[k] <= CONFIG_RESET;
    end else if (ce && wr_acc) begin
      for (int k = 0; k < NUM_SHAPERS; k++) begin
        if (cfg_sel[k]) cfg_r[k] <= pwdata & CONFIG_WMASK;
      end
    end
  end

  // Sticky congestion flag; a new event beats the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cong_flag_r <= '0;
    end else if (ce) begin
      cong_flag_r <= (cong_flag_r & ~read_clr) | cong_evt;
    end
  end

  // Interrupt status, write-one-to-clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
      irq_en_r <= '0;
    end else if (ce) begin
      irq_stat_r <= (irq_stat_r & ~((wr_acc && paddr == IRQ_CLEAR_ADDR) ? pwdata[3:0] : 4'h0))
        | cong_evt;
      if (wr_acc && paddr == IRQ_ENABLE_ADDR) irq_en_r <= pwdata[3:0];
    end
  end

  // Read mux; unmapped addresses return zero with error
  always_comb begin
    rdata_nxt = '0;
    for (int k = 0; k < NUM_SHAPERS; k++) begin
      if (cfg_sel[k]) rdata_nxt = cfg_r[k] | (32'(cong_flag_r[k]) << CONG_BIT);
    end
    if (paddr == IRQ_STATUS_ADDR) rdata_nxt = 32'(irq_stat_r);
    if (paddr == IRQ_ENABLE_ADDR) rdata_nxt = 32'(irq_en_r);
  end

  // Ready registered high after setup; prdata captured with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rdata_nxt : '0;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Queue override for shaped WAN pairs
  always_comb begin
    hit_idx = 2'd0;
    for (int k = NUM_SHAPERS - 1; k >= 0; k--) if (hit[k]) hit_idx = 2'(k);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_select_out <= '0;
      queue_shaped <= 1'b0;
      slot_tick_out <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      queue_shaped <= |hit;
      queue_select_out <= (|hit) ? hit_idx : circuit_queue_select;
      slot_tick_out <= slot_tick;
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  AST_FLAG_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cong_evt[0] |=> cong_flag_r[0]) else $error("flag not set");
  AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && read_clr[0] && !cong_evt[0] |=> !cong_flag_r[0]) else $error("read no clear");
  AST_OVERRIDE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |hit |=> queue_shaped) else $error("shaped pair not overridden");
  AST_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(|hit) |=> queue_select_out == $past(circuit_queue_select))
    else $error("unshaped select altered");
  AST_RO_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |-> cfg_r[0][CONG_BIT] == 1'b0) else $error("ro bit stored");
  AST_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cfg_r[1][EN_BIT] ##1 ce && !cfg_r[1][EN_BIT] |=> !slot_tick_out[1])
    else $error("disabled tick");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |(irq_stat_r & irq_en_r) |=> irq) else $error("irq missing");
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable |=> pready) else $error("no ready");
  COV_CONG: cover property (@(posedge pclk) cong_flag_r[0]);
  COV_READ: cover property (@(posedge pclk) rd_acc && cfg_sel[0]);
  COV_SHAPED: cover property (@(posedge pclk) queue_shaped);
endmodule

// >>> bench/queue_engine_model.sv
// Queue engine stand-in: class queue lengths and departure pulses.
// Assumes one clock; the bench sets one fill level for all queues.
`timescale 1ns/10ps
module queue_engine_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] fill,
  output logic [255:0] class_qlen,
  output logic [15:0] class_depart
);
  logic [2:0] tick_r;
  // Same level on every queue, so unshaped queues see congestion too
  assign class_qlen = {16{fill}};
  // One departure in eight cycles while cells wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 3'h0;
      class_depart <= 16'h0000;
    end else begin
      tick_r <= tick_r + 3'h1;
      class_depart <= (tick_r == 3'h0 && fill != 16'h0000) ? 16'h000f : 16'h0000;
    end
  end
endmodule

// >>> bench/wan_cell_shaper_bank_test.sv
// Bench for the shaper bank: APB tasks, queue engine model, checks.
// Assumes a 10 MHz clock; APB answer time is taken from pready only.
`timescale 1ns/10ps
module wan_cell_shaper_bank_test;
  import shaper_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, queue_shaped, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cfg;
  logic [255:0] class_qlen;
  logic [15:0] class_depart, fill;
  logic [1:0] lookup_port, lookup_class, circuit_queue_select, queue_select_out;
  logic [3:0] slot_tick_out;
  int num_errors, num_checks, gap;

  wan_cell_shaper_bank wan_cell_shaper_bank_i (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .class_qlen, .class_depart,
    .lookup_port, .lookup_class, .circuit_queue_select, .queue_select_out,
    .queue_shaped, .slot_tick_out, .irq);
  queue_engine_model queue_engine_model_i (.pclk, .presetn, .fill, .class_qlen,
    .class_depart);

  // Free-running 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; no latency assumed, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles
  initial begin
    #(5000 * 100);
    num_errors++;
    test_done();
  end

  // Test sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fill = 16'h0000;
    lookup_port = 2'h0;
    lookup_class = 2'h0;
    circuit_queue_select = 2'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, SHAPER0_CONFIG_ADDR + 12'(4 * i), 32'h0000_0000);
      check(rd, CONFIG_RESET);
    end
    check({31'h0, irq}, 32'h0000_0000);
    // Flag and unused bits must ignore writes
    apb(1'b1, SHAPER2_CONFIG_ADDR, 32'hffff_ffff);
    apb(1'b0, SHAPER2_CONFIG_ADDR, 32'h0000_0000);
    check(rd, CONFIG_WMASK);
    apb(1'b0, 12'h750, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    $display("test registers done");
    // Distinct pairs on all four; only shaper 0 slows, threshold code 2
    for (int i = 0; i < 4; i++) begin
      cfg = {3'h0, 9'(8 + i), 14'h0, 2'(i), (i == 0) ? 3'h3 : 3'h0, 1'b1};
      if (i == 0) cfg[15:12] = 4'h2;
      apb(1'b1, SHAPER0_CONFIG_ADDR + 12'(4 * i), cfg);
      apb(1'b0, SHAPER0_CONFIG_ADDR + 12'(4 * i), 32'h0000_0000);
      check(rd, cfg);
    end
    lookup_port <= 2'h3;
    circuit_queue_select <= 2'h2;
    repeat (3) @(posedge pclk);
    check({29'h0, queue_shaped, queue_select_out}, 32'h0000_0007);
    lookup_class <= 2'h1;
    repeat (3) @(posedge pclk);
    check({29'h0, queue_shaped, queue_select_out}, 32'h0000_0002);
    $display("test override done");
    // Unstretched shapers tick every rate cycles
    for (int i = 1; i < 4; i++) begin
      gap = 0;
      do @(posedge pclk); while (slot_tick_out[i] !== 1'b1);
      do begin
        @(posedge pclk);
        gap++;
      end while (slot_tick_out[i] !== 1'b1 && gap < 600);
      check(32'(gap), 32'(8 + i));
    end
    apb(1'b1, SHAPER3_CONFIG_ADDR, 32'h00b0_0030);
    lookup_class <= 2'h0;
    repeat (3) @(posedge pclk);
    check({29'h0, queue_shaped, queue_select_out}, 32'h0000_0002);
    $display("test slots done");
    // Level 5 sits under threshold 7 over two 64-cycle windows
    fill <= 16'h0005;
    repeat (140) @(posedge pclk);
    apb(1'b0, IRQ_STATUS_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    fill <= 16'h000a;
    repeat (140) @(posedge pclk);
    apb(1'b0, IRQ_STATUS_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, IRQ_ENABLE_ADDR, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0001);
    fill <= 16'h0000;
    apb(1'b0, SHAPER0_CONFIG_ADDR, 32'h0000_0000);
    check({31'h0, rd[31]}, 32'h0000_0001);
    apb(1'b0, SHAPER0_CONFIG_ADDR, 32'h0000_0000);
    check({31'h0, rd[31]}, 32'h0000_0000);
    apb(1'b1, IRQ_CLEAR_ADDR, 32'h0000_0001);
    apb(1'b0, IRQ_STATUS_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test congestion done");
    test_done();
  end
endmodule
